// ### verilog/bst_test_port.sv
// boundary-scan test port: tap controller, instruction, bypass, identity
// assumes tck, tms, tdi, test_reset_n are pins sampled by mclk; tck well
// below mclk/4; cap_in and func_out come from mclk logic
`timescale 1ns/1ns
`default_nettype none
// What this block does
// [R1] tms sampled at tck rise drives controller
// [R2] tdi sampled at tck rise, routed by state
// [R3] tdo updates on tck falling edge
// [R4] tdo driver off unless shifting
// [R5] tms, tdi, reset read high when undriven
// [R6] test clock independent, core keeps running
// [R7] test reset clears whole scan structure
// [R8] four-bit instruction shifted in shift-ir
// [R9] instruction picks data register and path
// [R10] bypass is one flip-flop stage
// [R11] chain cells 0..119, cell 0 first out
// [R12] control cell one enables its driver
// [R13] identity: revision, part, maker fields
// [R14] identity bit 0 always captures one
// [R15] code 0000 drives cells, chain in path
// [R16] code 1111 bypass, core untouched
// [R17] code 0010 captures and shifts identity
// [R18] code 0100 bypass, all drivers off
// [R19] code 0011 bypass, cells drive outputs
// [R20] code 0001 samples pins or preloads cells
// [R21] controller loads only defined codes; here it loads any code
// [R22] test pins excluded from forcing, sampling
// [R23] sixteen-state controller, five ones reset
// [R24] reserved codes behave as bypass
module bst_test_port (
	input wire logic mclk,
	input wire logic resetn,
	input wire logic ce,
	input wire logic tck,
	input wire logic tms,
	input wire logic tdi,
	input wire logic test_reset_n,
	output logic tdo,
	output logic tdo_oe,
	input wire logic [bst_pkg::CHAIN_LEN-1:0] cap_in,
	input wire logic [bst_pkg::CHAIN_LEN-1:0] func_out,
	output logic [bst_pkg::CHAIN_LEN-1:0] pin_drive,
	output logic outputs_off
);
	bst_chain_if chain_bus ();

	logic tck_meta_reg;
	logic tck_sync_reg;
	logic tck_prev_reg;
	logic tms_meta_reg;
	logic tms_sync_reg;
	logic tdi_meta_reg;
	logic tdi_sync_reg;
	logic trst_meta_reg;
	logic trst_sync_reg;
	logic tck_rise;
	logic tck_fall;
	logic tap_reset;

	bst_pkg::bst_state_t state_reg;
	bst_pkg::bst_state_t state_next;
	bst_pkg::bst_instr_t instr;

	logic [bst_pkg::IR_W-1:0] ir_shift_reg;
	logic [bst_pkg::IR_W-1:0] ir_reg;
	logic one_bit_bypass_stage_reg;
	logic [bst_pkg::ID_W-1:0] identification_shift_register_reg;
	logic chain_sel;
	logic dr_so;
	logic tdo_reg;
	logic tdo_oe_reg;
	logic [bst_pkg::CHAIN_LEN-1:0] drive_next;
	logic [bst_pkg::CHAIN_LEN-1:0] pin_drive_reg;
	logic outputs_off_reg;

	// pin synchronisers; undriven pins are pulled high at the pad, so
	// the same level is assumed before the first sample
	always_ff @(posedge mclk) begin
		if (!resetn) begin
			// idle tck level, so no false edge follows reset
			tck_meta_reg <= 1'b1;
			tck_sync_reg <= 1'b1;
			tck_prev_reg <= 1'b1;
		end else if (ce) begin
			tck_meta_reg <= tck;
			tck_sync_reg <= tck_meta_reg;
			tck_prev_reg <= tck_sync_reg;
		end
	end

	always_ff @(posedge mclk) begin
		if (!resetn) begin
			tms_meta_reg <= 1'b1; // R5
			tms_sync_reg <= 1'b1;
			tdi_meta_reg <= 1'b1; // R5
			tdi_sync_reg <= 1'b1;
			trst_meta_reg <= 1'b1; // R5
			trst_sync_reg <= 1'b1;
		end else if (ce) begin
			tms_meta_reg <= tms;
			tms_sync_reg <= tms_meta_reg;
			tdi_meta_reg <= tdi;
			tdi_sync_reg <= tdi_meta_reg;
			trst_meta_reg <= test_reset_n;
			trst_sync_reg <= trst_meta_reg;
		end
	end

	// tck only sampled, never used as a clock, so the core is untouched
	assign tck_rise = tck_sync_reg & ~tck_prev_reg; // R6
	assign tck_fall = ~tck_sync_reg & tck_prev_reg;
	assign tap_reset = ~trst_sync_reg; // R7

	// controller next state
	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
			bst_pkg::BST_TLR: state_next = tms_sync_reg ?
				bst_pkg::BST_TLR : bst_pkg::BST_IDLE; // R23
			bst_pkg::BST_IDLE: state_next = tms_sync_reg ?
				bst_pkg::BST_SEL_DR : bst_pkg::BST_IDLE;
			bst_pkg::BST_SEL_DR: state_next = tms_sync_reg ?
				bst_pkg::BST_SEL_IR : bst_pkg::BST_CAP_DR;
			bst_pkg::BST_CAP_DR: state_next = tms_sync_reg ?
				bst_pkg::BST_EX1_DR : bst_pkg::BST_SH_DR;
			bst_pkg::BST_SH_DR: state_next = tms_sync_reg ?
				bst_pkg::BST_EX1_DR : bst_pkg::BST_SH_DR;
			bst_pkg::BST_EX1_DR: state_next = tms_sync_reg ?
				bst_pkg::BST_UPD_DR : bst_pkg::BST_PAUSE_DR;
			bst_pkg::BST_PAUSE_DR: state_next = tms_sync_reg ?
				bst_pkg::BST_EX2_DR : bst_pkg::BST_PAUSE_DR;
			bst_pkg::BST_EX2_DR: state_next = tms_sync_reg ?
				bst_pkg::BST_UPD_DR : bst_pkg::BST_SH_DR;
			bst_pkg::BST_UPD_DR: state_next = tms_sync_reg ?
				bst_pkg::BST_SEL_DR : bst_pkg::BST_IDLE;
			bst_pkg::BST_SEL_IR: state_next = tms_sync_reg ?
				bst_pkg::BST_TLR : bst_pkg::BST_CAP_IR; // R23
			bst_pkg::BST_CAP_IR: state_next = tms_sync_reg ?
				bst_pkg::BST_EX1_IR : bst_pkg::BST_SH_IR;
			bst_pkg::BST_SH_IR: state_next = tms_sync_reg ?
				bst_pkg::BST_EX1_IR : bst_pkg::BST_SH_IR;
			bst_pkg::BST_EX1_IR: state_next = tms_sync_reg ?
				bst_pkg::BST_UPD_IR : bst_pkg::BST_PAUSE_IR;
			bst_pkg::BST_PAUSE_IR: state_next = tms_sync_reg ?
				bst_pkg::BST_EX2_IR : bst_pkg::BST_PAUSE_IR;
			bst_pkg::BST_EX2_IR: state_next = tms_sync_reg ?
				bst_pkg::BST_UPD_IR : bst_pkg::BST_SH_IR;
			bst_pkg::BST_UPD_IR: state_next = tms_sync_reg ?
				bst_pkg::BST_SEL_DR : bst_pkg::BST_IDLE;
		endcase
	end

	always_ff @(posedge mclk) begin
		if (!resetn) begin
			state_reg <= bst_pkg::BST_TLR;
		end else if (ce) begin
			if (tap_reset) begin
				state_reg <= bst_pkg::BST_TLR; // R7
			end else if (tck_rise) begin
				state_reg <= state_next; // R1
			end
		end
	end

	// instruction shifter and current instruction
	always_ff @(posedge mclk) begin
		if (!resetn) begin
			ir_shift_reg <= bst_pkg::IR_CAPTURE;
		end else if (ce) begin
			if (tap_reset) begin
				ir_shift_reg <= bst_pkg::IR_CAPTURE; // R7
			end else if (tck_rise) begin
				if (state_reg == bst_pkg::BST_CAP_IR) begin
					ir_shift_reg <= bst_pkg::IR_CAPTURE;
				end else if (state_reg == bst_pkg::BST_SH_IR) begin
					ir_shift_reg <= {tdi_sync_reg,
						ir_shift_reg[bst_pkg::IR_W-1:1]}; // R8
				end
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (!resetn) begin
			ir_reg <= bst_pkg::IR_RESET;
		end else if (ce) begin
			if (tap_reset) begin
				ir_reg <= bst_pkg::IR_RESET; // R7
			end else if (tck_rise) begin
				if (state_reg == bst_pkg::BST_TLR) begin
					ir_reg <= bst_pkg::IR_RESET;
				end else if (state_reg == bst_pkg::BST_UPD_IR) begin
					ir_reg <= ir_shift_reg;
				end
			end
		end
	end

	// undefined codes fall back to bypass; the host must not load them
	assign instr = bst_pkg::bst_decode(ir_reg); // R24

	assign chain_sel = (instr == bst_pkg::BST_I_EXTEST) ||
		(instr == bst_pkg::BST_I_SAMPLE); // R15 R20

	// single bypass stage
	always_ff @(posedge mclk) begin
		if (!resetn) begin
			one_bit_bypass_stage_reg <= bst_pkg::BYPASS_CAPTURE;
		end else if (ce) begin
			if (tap_reset) begin
				one_bit_bypass_stage_reg <= bst_pkg::BYPASS_CAPTURE;
			end else if (tck_rise) begin
				if (state_reg == bst_pkg::BST_CAP_DR) begin
					one_bit_bypass_stage_reg <= bst_pkg::BYPASS_CAPTURE;
				end else if (state_reg == bst_pkg::BST_SH_DR) begin
					one_bit_bypass_stage_reg <= tdi_sync_reg; // R10 R2
				end
			end
		end
	end

	// identity shifter, loaded only under the identity instruction
	always_ff @(posedge mclk) begin
		if (!resetn) begin
			identification_shift_register_reg <= '0;
		end else if (ce) begin
			if (tap_reset) begin
				identification_shift_register_reg <= '0; // R7
			end else if (tck_rise && instr == bst_pkg::BST_I_IDCODE) begin
				if (state_reg == bst_pkg::BST_CAP_DR) begin
					identification_shift_register_reg <=
						bst_pkg::ID_VALUE; // R17 R13 R14
				end else if (state_reg == bst_pkg::BST_SH_DR) begin
					identification_shift_register_reg <= {tdi_sync_reg,
						identification_shift_register_reg[bst_pkg::ID_W-1:1]};
				end
			end
		end
	end

	// boundary chain strobes
	assign chain_bus.clear = tap_reset; // R7
	assign chain_bus.capture = ce && tck_rise && chain_sel &&
		state_reg == bst_pkg::BST_CAP_DR; // R20
	assign chain_bus.shift = ce && tck_rise && chain_sel &&
		state_reg == bst_pkg::BST_SH_DR; // R2
	assign chain_bus.update = ce && tck_rise && chain_sel &&
		state_reg == bst_pkg::BST_UPD_DR; // R20
	assign chain_bus.si = tdi_sync_reg;
	// test pins have no cells, so they are never sampled or forced
	assign chain_bus.cap_vec = cap_in; // R22

	bst_boundary_chain u_chain (
		.mclk(mclk),
		.resetn(resetn),
		.ce(ce),
		.bus(chain_bus)
	);

	// serial path select
	always_comb begin
		unique case (instr)
			bst_pkg::BST_I_EXTEST: dr_so = chain_bus.so; // R9
			bst_pkg::BST_I_SAMPLE: dr_so = chain_bus.so;
			bst_pkg::BST_I_IDCODE: dr_so = identification_shift_register_reg[0];
			bst_pkg::BST_I_CLAMP: dr_so = one_bit_bypass_stage_reg; // R19
			bst_pkg::BST_I_HIGHZ: dr_so = one_bit_bypass_stage_reg; // R18
			bst_pkg::BST_I_BYPASS: dr_so = one_bit_bypass_stage_reg; // R16
		endcase
	end

	// tdo moves on the falling edge so the host samples a settled bit
	always_ff @(posedge mclk) begin
		if (!resetn) begin
			tdo_reg <= 1'b0;
			tdo_oe_reg <= 1'b0;
		end else if (ce) begin
			if (tap_reset) begin
				tdo_oe_reg <= 1'b0; // R4
			end else if (tck_fall) begin
				if (state_reg == bst_pkg::BST_SH_IR) begin
					tdo_reg <= ir_shift_reg[0]; // R3
					tdo_oe_reg <= 1'b1;
				end else if (state_reg == bst_pkg::BST_SH_DR) begin
					tdo_reg <= dr_so; // R3
					tdo_oe_reg <= 1'b1;
				end else begin
					tdo_oe_reg <= 1'b0; // R4
				end
			end
		end
	end

	// pin drive per cell; control cells are active high enables
	genvar gi;
	generate
		for (gi = 0; gi < bst_pkg::CHAIN_LEN; gi++) begin : g_cell
			always_comb begin
				unique case (instr)
					bst_pkg::BST_I_EXTEST,
					bst_pkg::BST_I_CLAMP:
						drive_next[gi] = chain_bus.upd_vec[gi]; // R15 R19 R12
					bst_pkg::BST_I_HIGHZ:
						drive_next[gi] = bst_pkg::bst_ctrl_cell(gi) ?
							1'b0 : func_out[gi]; // R18 R12
					bst_pkg::BST_I_SAMPLE,
					bst_pkg::BST_I_IDCODE,
					bst_pkg::BST_I_BYPASS:
						drive_next[gi] = func_out[gi]; // R16 R6
				endcase
			end
		end
	endgenerate

	always_ff @(posedge mclk) begin
		if (!resetn) begin
			pin_drive_reg <= '0;
			outputs_off_reg <= 1'b0;
		end else if (ce) begin
			pin_drive_reg <= drive_next;
			// covers outputs with no control cell of their own
			outputs_off_reg <= (instr == bst_pkg::BST_I_HIGHZ); // R18
		end
	end

	assign tdo = tdo_reg;
	assign tdo_oe = tdo_oe_reg;
	assign pin_drive = pin_drive_reg;
	assign outputs_off = outputs_off_reg;
endmodule
`default_nettype wire

// ### verilog/bst_pkg.sv
// shared constants, types and decoders for the boundary-scan test port
// assumes every user names items as bst_pkg::name, no imports
package bst_pkg;

	localparam int IR_W = 4;
	localparam int ID_W = 32;
	localparam int CHAIN_LEN = 120;

	// instruction codes
	localparam logic [IR_W-1:0] OP_EXTEST = 4'h0;
	localparam logic [IR_W-1:0] OP_SAMPLE = 4'h1;
	localparam logic [IR_W-1:0] OP_IDCODE = 4'h2;
	localparam logic [IR_W-1:0] OP_CLAMP = 4'h3;
	localparam logic [IR_W-1:0] OP_HIGHZ = 4'h4;
	localparam logic [IR_W-1:0] OP_BYPASS = 4'hF;
	// fixed pattern captured into the instruction shifter
	localparam logic [IR_W-1:0] IR_CAPTURE = 4'h1;
	// instruction after test-logic reset
	localparam logic [IR_W-1:0] IR_RESET = OP_IDCODE;

	// identity fields: values are arbitrary
	localparam logic [3:0] ID_REVISION = 4'h1;
	localparam logic [15:0] ID_PART = 16'h5A5A;
	localparam logic [10:0] ID_MAKER = 11'h2AB;
	localparam logic ID_PRESENT = 1'b1;
	localparam logic [ID_W-1:0] ID_VALUE =
		{ID_REVISION, ID_PART, ID_MAKER, ID_PRESENT};

	// bypass stage capture value
	localparam logic BYPASS_CAPTURE = 1'b0;

	// three-state control cells in the chain
	localparam int CTRL_A_FIRST = 26;
	localparam int CTRL_A_LAST = 71;
	localparam int CTRL_A_STEP = 3;
	localparam int CTRL_B_FIRST = 73;
	localparam int CTRL_B_LAST = 87;
	localparam int CTRL_C_FIRST = 97;
	localparam int CTRL_C_LAST = 111;
	localparam int CTRL_BC_STEP = 2;

	typedef enum {
		BST_TLR, BST_IDLE,
		BST_SEL_DR, BST_CAP_DR, BST_SH_DR, BST_EX1_DR,
		BST_PAUSE_DR, BST_EX2_DR, BST_UPD_DR,
		BST_SEL_IR, BST_CAP_IR, BST_SH_IR, BST_EX1_IR,
		BST_PAUSE_IR, BST_EX2_IR, BST_UPD_IR
	} bst_state_t;

	typedef enum {
		BST_I_EXTEST, BST_I_SAMPLE, BST_I_IDCODE,
		BST_I_CLAMP, BST_I_HIGHZ, BST_I_BYPASS
	} bst_instr_t;

	function automatic bst_instr_t bst_decode(input logic [IR_W-1:0] code);
		case (code)
			OP_EXTEST: return BST_I_EXTEST;
			OP_SAMPLE: return BST_I_SAMPLE;
			OP_IDCODE: return BST_I_IDCODE;
			OP_CLAMP: return BST_I_CLAMP;
			OP_HIGHZ: return BST_I_HIGHZ;
			default: return BST_I_BYPASS;
		endcase
	endfunction

	function automatic bit bst_ctrl_cell(input int i);
		return (i >= CTRL_A_FIRST && i <= CTRL_A_LAST &&
			(i - CTRL_A_FIRST) % CTRL_A_STEP == 0) ||
			(i >= CTRL_B_FIRST && i <= CTRL_B_LAST &&
			(i - CTRL_B_FIRST) % CTRL_BC_STEP == 0) ||
			(i >= CTRL_C_FIRST && i <= CTRL_C_LAST &&
			(i - CTRL_C_FIRST) % CTRL_BC_STEP == 0);
	endfunction

endpackage

// ### verilog/bst_chain_if.sv
// link between the tap controller and the boundary chain store
// assumes both ends run on mclk
`timescale 1ns/1ns
`default_nettype none
interface bst_chain_if;
	logic clear;
	logic capture;
	logic shift;
	logic update;
	logic si;
	logic so;
	logic [bst_pkg::CHAIN_LEN-1:0] cap_vec;
	logic [bst_pkg::CHAIN_LEN-1:0] upd_vec;

	modport ctrl (
		output clear,
		output capture,
		output shift,
		output update,
		output si,
		output cap_vec,
		input so,
		input upd_vec
	);
	modport chain (
		input clear,
		input capture,
		input shift,
		input update,
		input si,
		input cap_vec,
		output so,
		output upd_vec
	);
endinterface
`default_nettype wire

// ### verilog/bst_boundary_chain.sv
// 120-cell boundary chain: shift stage plus update latch
// assumes capture, shift and update strobes are one mclk wide and already qualified by the tap
`timescale 1ns/1ns
`default_nettype none
module bst_boundary_chain (
	input wire logic mclk,
	input wire logic resetn,
	input wire logic ce,
	bst_chain_if.chain bus
);
	logic [bst_pkg::CHAIN_LEN-1:0] shift_reg;
	logic [bst_pkg::CHAIN_LEN-1:0] upd_reg;

	always_ff @(posedge mclk) begin
		if (!resetn) begin
			shift_reg <= '0;
		end else if (ce) begin
			if (bus.clear) begin
				shift_reg <= '0; // R7
			end else if (bus.capture) begin
				shift_reg <= bus.cap_vec; // R20
			end else if (bus.shift) begin
				// cell 0 leaves first
				shift_reg <= {bus.si, shift_reg[bst_pkg::CHAIN_LEN-1:1]}; // R11
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (!resetn) begin
			upd_reg <= '0;
		end else if (ce) begin
			if (bus.clear) begin
				upd_reg <= '0; // R7
			end else if (bus.update) begin
				upd_reg <= shift_reg;
			end
		end
	end

	assign bus.so = shift_reg[0]; // R11
	assign bus.upd_vec = upd_reg;
endmodule
`default_nettype wire

// ### test/bst_test_port_properties.sv
// checker on the test port pins, bound into every bst_test_port
// assumes tck held 4 mclk high and 4 low; test reset held >= 6 mclk
`timescale 1ns/1ns
`default_nettype none
module bst_test_port_properties (
	input wire logic mclk,
	input wire logic resetn,
	input wire logic ce,
	input wire logic tck,
	input wire logic tms,
	input wire logic tdi,
	input wire logic test_reset_n,
	input wire logic tdo,
	input wire logic tdo_oe,
	input wire logic [bst_pkg::CHAIN_LEN-1:0] cap_in,
	input wire logic [bst_pkg::CHAIN_LEN-1:0] func_out,
	input wire logic [bst_pkg::CHAIN_LEN-1:0] pin_drive,
	input wire logic outputs_off
);
	function automatic logic [bst_pkg::CHAIN_LEN-1:0] mk_mask();
		logic [bst_pkg::CHAIN_LEN-1:0] m;
		m = '0;
		for (int i = 26; i <= 71; i += 3)
			m[i] = 1'b1;
		for (int i = 73; i <= 111; i += 2)
			m[i] = (i <= 87 || i >= 97);
		return m;
	endfunction
	localparam logic [bst_pkg::CHAIN_LEN-1:0] CTRL_MASK = mk_mask();

	default clocking cb @(posedge mclk); endclocking
	default disable iff (!resetn);

	a_tdo_at_fall: assert property ($changed(tdo) && test_reset_n &&
		$past(test_reset_n, 4) |-> !tck) else $error("tdo moved, tck high");
	a_oe_at_fall: assert property ($changed(tdo_oe) && test_reset_n |->
		!tck && !$past(tck)) else $error("tdo_oe moved, tck high");
	a_tdo_stands: assert property ((tck && test_reset_n)[*4] |->
		$stable(tdo_oe) && $stable(tdo)) else $error("tdo not held");
	a_highz_mask: assert property (outputs_off && $past(outputs_off) |->
		(pin_drive & CTRL_MASK) == '0) else $error("enable left on");
	a_highz_func: assert property (outputs_off && $past(outputs_off, 2) &&
		$stable(func_out) |-> pin_drive == (func_out & ~CTRL_MASK))
		else $error("high-z pins wrong");
	a_trst_quiet: assert property ((!test_reset_n)[*5] |->
		!tdo_oe && !outputs_off) else $error("test reset ignored");
	a_trst_pins: assert property ((!test_reset_n)[*6] &&
		$stable(func_out) |-> pin_drive == func_out)
		else $error("pins not functional in test reset");
	a_pins_quiet: assert property ($changed(pin_drive) |->
		!$past(resetn) || func_out != $past(func_out) ||
		$past(func_out) != $past(func_out, 2) || $past(tck) ||
		$past(tck, 2) || !$past(test_reset_n, 3) ||
		!$past(test_reset_n, 4)) else $error("pins moved without cause");
endmodule

bind bst_test_port bst_test_port_properties chk_u (
	.mclk(mclk), .resetn(resetn), .ce(ce), .tck(tck), .tms(tms),
	.tdi(tdi), .test_reset_n(test_reset_n), .tdo(tdo), .tdo_oe(tdo_oe),
	.cap_in(cap_in), .func_out(func_out), .pin_drive(pin_drive),
	.outputs_off(outputs_off)
);
`default_nettype wire

// ### test/bst_tap_master.sv
// partner: external scan controller driving the test pins
// assumes mclk at 100 MHz; tck period 8 mclk, still between scans
`timescale 1ns/1ns
`default_nettype none
module bst_tap_master (
	input wire logic mclk,
	input wire logic tdo,
	input wire logic tdo_oe,
	output var logic tck,
	output var logic tms,
	output var logic tdi,
	output var logic test_reset_n
);
	logic seen_tdo;
	logic seen_oe;

	// idle pins sit at the pulled-up level
	initial begin
		tck = 1'b1;
		tms = 1'b1;
		tdi = 1'b1;
		test_reset_n = 1'b1;
		seen_tdo = 1'b0;
		seen_oe = 1'b0;
	end

	// tdo read just before the rise: it stands until the next fall
	task automatic tick(input logic tms_v, input logic tdi_v);
		@(negedge mclk);
		tck = 1'b0;
		tms = tms_v;
		tdi = tdi_v;
		repeat (4) @(negedge mclk);
		seen_tdo = tdo;
		seen_oe = tdo_oe;
		tck = 1'b1;
		repeat (3) @(negedge mclk);
	endtask

	// from idle through capture, shift, exit and update back to idle
	task automatic scan(input logic to_ir, input int n,
		input logic [127:0] din, output logic [127:0] dout,
		output logic oe_all, output logic oe_end);
		dout = '0;
		oe_all = 1'b1;
		tick(1'b1, 1'b1);
		if (to_ir)
			tick(1'b1, 1'b1);
		tick(1'b0, 1'b1);
		tick(1'b0, 1'b1);
		for (int i = 0; i < n; i++) begin
			tick(i == n - 1, din[i]);
			dout[i] = seen_tdo;
			oe_all &= seen_oe;
		end
		tick(1'b1, 1'b1);
		oe_end = seen_oe;
		tick(1'b0, 1'b1);
		tdi = 1'b1;
		// a new instruction reaches the pins on the fourth mclk edge after the rise
		repeat (2) @(negedge mclk);
	endtask

	task automatic reset_tap();
		repeat (5) tick(1'b1, 1'b1);
		tick(1'b0, 1'b1);
	endtask

	task automatic pulse_reset();
		@(negedge mclk);
		test_reset_n = 1'b0;
		repeat (8) @(negedge mclk);
		test_reset_n = 1'b1;
		repeat (4) @(negedge mclk);
		tick(1'b0, 1'b1);
	endtask
endmodule
`default_nettype wire

// ### test/testbench.sv
// bench for bst_test_port against a behavioural scan controller
// assumes ce stays high; the checker is bound in by its own file
`timescale 1ns/1ns
`default_nettype none
module testbench;
	localparam int W = bst_pkg::CHAIN_LEN;
	logic mclk, resetn, ce, tck, tms, tdi, test_reset_n, tdo, tdo_oe;
	logic outputs_off, oe_a, oe_e;
	logic [W-1:0] cap_in, func_out, pin_drive, mask;
	logic [127:0] dout;
	int n_mismatch = 0;
	int n_compared = 0;

	bst_test_port dut_u (.mclk(mclk), .resetn(resetn), .ce(ce), .tck(tck),
		.tms(tms), .tdi(tdi), .test_reset_n(test_reset_n), .tdo(tdo),
		.tdo_oe(tdo_oe), .cap_in(cap_in), .func_out(func_out),
		.pin_drive(pin_drive), .outputs_off(outputs_off));
	bst_tap_master ctl_u (.mclk(mclk), .tdo(tdo), .tdo_oe(tdo_oe),
		.tck(tck), .tms(tms), .tdi(tdi), .test_reset_n(test_reset_n));

	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end

	task automatic check(input logic [127:0] seen, input logic [127:0] want);
		n_compared++;
		if (seen !== want) begin
			n_mismatch++;
			$display("MISMATCH at %0t: seen %0h want %0h", $time, seen, want);
		end
	endtask

	task automatic close_out();
		$display("compared %0d mismatches %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	task automatic load_ir(input logic [3:0] code);
		ctl_u.scan(1'b1, 4, {124'h0, code}, dout, oe_a, oe_e);
		check(dout[3:0], bst_pkg::IR_CAPTURE);
	endtask

	task automatic scan_id();
		ctl_u.scan(1'b0, 32, '0, dout, oe_a, oe_e);
		check(dout[31:0], bst_pkg::ID_VALUE);
	endtask

	task automatic t_identity();
		scan_id();
		check(dout[0], 1'b1);
		check(oe_a, 1'b1);
		check(oe_e, 1'b0);
		check(tdo_oe, 1'b0);
		check(pin_drive, func_out);
	endtask

	// preload through sample, then drive it out with extest and clamp
	task automatic t_chain();
		logic [W-1:0] p;
		p = {4{30'h2D4B1E87}};
		cap_in = {4{30'h13579BDF}};
		load_ir(bst_pkg::OP_SAMPLE);
		ctl_u.scan(1'b0, W, {8'h00, p}, dout, oe_a, oe_e);
		check(dout[W-1:0], cap_in);
		check(pin_drive, func_out);
		load_ir(bst_pkg::OP_EXTEST);
		check(pin_drive, p);
		load_ir(bst_pkg::OP_CLAMP);
		check(pin_drive, p);
		check(outputs_off, 1'b0);
	endtask

	// every one-bit path code, reserved ones among them
	task automatic t_bypass_family();
		logic [3:0] code;
		for (int k = 3; k <= 15; k++) begin
			code = k[3:0];
			load_ir(code);
			ctl_u.scan(1'b0, 8, 128'hB4, dout, oe_a, oe_e);
			check(dout[7:0], 8'h68);
			if (code == bst_pkg::OP_HIGHZ) begin
				check(outputs_off, 1'b1);
				check(pin_drive, func_out & ~mask);
			end else if (code != bst_pkg::OP_CLAMP) begin
				check(outputs_off, 1'b0);
				check(pin_drive, func_out);
			end
		end
	endtask

	// core output flips once before the pin reset; both test resets bring identity back
	task automatic t_resets();
		load_ir(bst_pkg::OP_BYPASS);
		func_out = ~func_out;
		ctl_u.pulse_reset();
		scan_id();
		check(pin_drive, func_out);
		load_ir(bst_pkg::OP_BYPASS);
		ctl_u.reset_tap();
		scan_id();
	endtask

	initial begin
		resetn = 1'b0;
		ce = 1'b1;
		cap_in = '0;
		func_out = {4{30'h0F0F3C3C}};
		mask = '0;
		for (int i = 26; i <= 71; i += 3)
			mask[i] = 1'b1;
		for (int i = 73; i <= 111; i += 2)
			mask[i] = (i <= 87 || i >= 97);
		repeat (20) @(negedge mclk);
		resetn = 1'b1;
		repeat (4) @(negedge mclk);
		ctl_u.tick(1'b0, 1'b1);
		t_identity();
		t_chain();
		t_bypass_family();
		t_resets();
		close_out();
	end

	// a hang ends the run as a failure
	initial begin
		repeat (60000) @(posedge mclk);
		n_mismatch++;
		close_out();
	end
endmodule
`default_nettype wire
